// File: core/can_ctl0_pkg.sv
// Package: register map, bit positions, reset values and timing for control register 0 block
package can_ctl0_pkg;
  // Register byte offsets
  localparam logic [7:0] ctl0_off      = 8'h00;
  localparam logic [7:0] ctl1_off      = 8'h04;
  localparam logic [7:0] stamp_off     = 8'h08;
  localparam logic [7:0] irq_stat_off  = 8'h0C;
  localparam logic [7:0] irq_mask_off  = 8'h10;
  localparam logic [7:0] tx_pend_off   = 8'h14;
  // Control register 0 bit positions
  localparam int rx_frame_bit  = 7;
  localparam int rx_active_bit = 6;
  localparam int stop_wait_bit = 5;
  localparam int synced_bit    = 4;
  localparam int time_en_bit   = 3;
  localparam int wake_en_bit   = 2;
  localparam int sleep_req_bit = 1;
  localparam int init_req_bit  = 0;
  // Control register 1 status bit positions
  localparam int sleep_ack_bit = 1;
  localparam int init_ack_bit  = 0;
  // Interrupt status bit positions
  localparam int ev_frame_bit  = 0;
  localparam int ev_stamp_bit  = 1;
  localparam int ev_wake_bit   = 2;
  localparam int ev_width      = 3;
  // Reset values
  localparam logic [7:0] ctl0_rst       = 8'h01;
  localparam logic [15:0] stamp_rst     = 16'h0000;
  localparam logic [2:0] irq_rst        = 3'h0;
  // Resynchronisation figures
  localparam int recessive_run          = 11;
  localparam int busoff_runs            = 128;
  localparam logic [3:0] recessive_cnt  = 4'hB;
  localparam logic [7:0] busoff_cnt     = 8'h80;
  // Pin input synchroniser depth
  localparam int sync_depth             = 3;
endpackage : can_ctl0_pkg

// File: core/pin_sync.sv
// Three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ns
module pin_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and filtered level
  input  wire logic din,
  output logic      dout
);
  logic [can_ctl0_pkg::sync_depth-1:0] stage_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_r <= '0;
    else
      stage_r <= {stage_r[can_ctl0_pkg::sync_depth-2:0], din};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout <= 1'b0;
    else if (stage_r[1] == stage_r[2])
      dout <= stage_r[2];
  end
endmodule : pin_sync

// File: core/can_control0_timestamp.sv
// Control register 0, mode handshakes, timestamp timer and interrupts behind an APB slave
// Operation
// R1 - Register reads return values sampled on the module clock.
// R2 - In init mode control register 0 stays reset, except wake, sleep and init bits.
// R3 - Writes accepted only outside init mode; status bits read-only; init bit always writable.
// R4 - Received-frame flag set on any valid message; sticky until cleared or reset.
// R5 - Writing one clears the received-frame flag; writing zero does nothing.
// R6 - Received-frame and receiver-active bits are meaningless in loopback mode.
// R7 - Receiver-active bit is one while receiving, zero while transmitting or idle.
// R8 - Stop-in-wait set gates the bus interface clock during wait mode.
// R9 - Synchronized bit is one when synced to the bus, set by hardware.
// R10 - Timer enable starts a 16-bit free-running counter at bit rate.
// R11 - Enabled timer value stored into buffer top bytes on acknowledge.
// R12 - Clearing timer enable resets the counter to zero.
// R13 - Timer enable forced low while init mode is active.
// R14 - Reserved buffer bits read undefined since buffers are RAM.
// R15 - Software writes to read-only status bits have no effect.
// R16 - Init request aborts transfers, drops sync, then sets init acknowledge; here the synchronized bit clears one cycle after init acknowledge.
// R17 - Resync after 11 recessive bits, or 128 such runs when bus-off.
// R18 - Sleep entered only when not receiving and transmit buffers empty.
// R19 - With wake enable, bus activity clears sleep request; otherwise ignored.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module can_control0_timestamp (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Protocol engine events, same clock
  input  wire logic        bit_tick,
  input  wire logic        frame_valid,
  input  wire logic        rx_in_progress,
  input  wire logic        msg_acked,
  input  wire logic        bus_off,
  input  wire logic        tx_buffers_empty,
  // Receive pin and wait mode, asynchronous
  input  wire logic        rx_pin,
  input  wire logic        cpu_wait,
  // Engine controls
  output logic             abort_transfer,
  output logic             tx_force_recessive,
  output logic             bus_clk_en,
  // Timestamp write into the active buffer
  output logic             stamp_we,
  output logic [15:0]      stamp_value,
  // Interrupt
  output logic             irq
);
  typedef enum {run_s, init_s, resync_s, sleep_s} mode_t;

  mode_t       mode_r;
  logic        rx_frame_r;
  logic        stop_wait_r;
  logic        time_en_r;
  logic        wake_en_r;
  logic        sleep_req_r;
  logic        init_req_r;
  logic        synced_r;
  logic        rx_active_r;
  logic [15:0] stamp_cnt_r;
  logic [15:0] stamp_value_r;
  logic        stamp_we_r;
  logic [3:0]  rec_run_r;
  logic [7:0]  run_cnt_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [31:0] prdata_r;
  logic        rx_pin_s;
  logic        wait_s;
  logic        rx_pin_d_r;
  logic        init_mode;
  logic        wr_en;
  logic        rd_en;
  logic        ctl0_wr;
  logic        rx_edge;
  logic [2:0]  ev_set;
  logic [7:0]  ctl0_val;
  logic [7:0]  ctl1_val;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  pin_sync u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (rx_pin),
    .dout    (rx_pin_s)
  );

  pin_sync u_wait_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (cpu_wait),
    .dout    (wait_s)
  );

  assign pready    = 1'b1;
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign pslverr   = psel && penable && !(hit(paddr, can_ctl0_pkg::ctl0_off) || hit(paddr, can_ctl0_pkg::ctl1_off)
                     || hit(paddr, can_ctl0_pkg::stamp_off) || hit(paddr, can_ctl0_pkg::irq_stat_off)
                     || hit(paddr, can_ctl0_pkg::irq_mask_off));
  assign ctl0_wr   = wr_en && hit(paddr, can_ctl0_pkg::ctl0_off);
  // R16 init acknowledged
  assign init_mode = (mode_r == init_s);
  assign rx_edge   = rx_pin_d_r && !rx_pin_s;

  // R16 abort and force recessive
  assign abort_transfer     = init_req_r;
  assign tx_force_recessive = init_req_r || (wait_s && stop_wait_r);
  // R8 clock gate enable
  assign bus_clk_en         = !(wait_s && stop_wait_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_pin_d_r <= 1'b0;
    else
      rx_pin_d_r <= rx_pin_s;
  end

  // Mode sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= init_s;
    else
    begin
      case (mode_r)
        run_s:
          if (init_req_r)
            mode_r <= init_s;
          // R18 sleep only when idle
          else if (sleep_req_r && !rx_in_progress && tx_buffers_empty)
            mode_r <= sleep_s;
        init_s:
          if (!init_req_r)
            mode_r <= resync_s;
        resync_s:
          if (init_req_r)
            mode_r <= init_s;
          else if (synced_r)
            mode_r <= run_s;
        sleep_s:
          if (init_req_r)
            mode_r <= init_s;
          else if (!sleep_req_r)
            mode_r <= run_s;
        default:
          mode_r <= init_s;
      endcase
    end
  end

  // R17 recessive run counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_run_r <= '0;
      run_cnt_r <= '0;
      synced_r  <= 1'b0;
    end
    else if (mode_r != resync_s)
    begin
      rec_run_r <= '0;
      run_cnt_r <= '0;
      // R9 synced while running normally
      synced_r  <= (mode_r == run_s);
    end
    else if (bit_tick)
    begin
      if (!rx_pin_s)
        rec_run_r <= '0;
      else if (rec_run_r == can_ctl0_pkg::recessive_cnt - 4'h1)
      begin
        rec_run_r <= '0;
        if (!bus_off || run_cnt_r == can_ctl0_pkg::busoff_cnt - 8'h01)
          synced_r <= 1'b1;
        else
          run_cnt_r <= run_cnt_r + 8'h01;
      end
      else
        rec_run_r <= rec_run_r + 4'h1;
    end
  end

  // R7 receiver front end status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_active_r <= 1'b0;
    else
      rx_active_r <= !init_mode && rx_in_progress;
  end

  // Writable control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_wait_r <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::stop_wait_bit];
      time_en_r   <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::time_en_bit];
      wake_en_r   <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::wake_en_bit];
      sleep_req_r <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::sleep_req_bit];
      init_req_r  <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::init_req_bit];
    end
    else
    begin
      // R2 held in reset during init
      if (init_mode)
      begin
        stop_wait_r <= can_ctl0_pkg::ctl0_rst[can_ctl0_pkg::stop_wait_bit];
        // R13 timer forced off
        time_en_r   <= 1'b0;
      end
      // R3 write gating outside init
      else if (ctl0_wr && !init_req_r)
      begin
        stop_wait_r <= pwdata[can_ctl0_pkg::stop_wait_bit];
        time_en_r   <= pwdata[can_ctl0_pkg::time_en_bit];
      end
      if (ctl0_wr && !(init_req_r && !init_mode))
        wake_en_r <= pwdata[can_ctl0_pkg::wake_en_bit];
      // R3 init bit writable in init mode
      if (ctl0_wr && (init_mode || !init_req_r))
        init_req_r <= pwdata[can_ctl0_pkg::init_req_bit];
      // R19 wake clears sleep request
      if (mode_r == sleep_s && wake_en_r && rx_edge)
        sleep_req_r <= 1'b0;
      else if (ctl0_wr && !(sleep_req_r && mode_r != sleep_s))
        sleep_req_r <= pwdata[can_ctl0_pkg::sleep_req_bit];
    end
  end

  // R4 sticky received-frame flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_frame_r <= 1'b0;
    else if (init_mode)
      rx_frame_r <= 1'b0;
    else if (frame_valid)
      rx_frame_r <= 1'b1;
    // R5 write one to clear
    else if (ctl0_wr && pwdata[can_ctl0_pkg::rx_frame_bit])
      rx_frame_r <= 1'b0;
  end

  // R10 free-running timestamp counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stamp_cnt_r <= can_ctl0_pkg::stamp_rst;
    // R12 reset when disabled
    else if (!time_en_r)
      stamp_cnt_r <= can_ctl0_pkg::stamp_rst;
    else if (bit_tick)
      stamp_cnt_r <= stamp_cnt_r + 16'h0001;
  end

  // R11 capture on acknowledge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stamp_we_r    <= 1'b0;
      stamp_value_r <= can_ctl0_pkg::stamp_rst;
    end
    else
    begin
      stamp_we_r <= time_en_r && msg_acked;
      if (time_en_r && msg_acked)
        stamp_value_r <= stamp_cnt_r;
    end
  end

  assign stamp_we    = stamp_we_r;
  assign stamp_value = stamp_value_r;

  // Interrupt status, set wins over clear
  assign ev_set = {(mode_r == sleep_s) && wake_en_r && rx_edge, stamp_we_r, frame_valid && !init_mode};

  genvar gi;
  generate
    for (gi = 0; gi < can_ctl0_pkg::ev_width; gi++)
    begin : g_irq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_stat_r[gi] <= can_ctl0_pkg::irq_rst[gi];
        else if (ev_set[gi])
          irq_stat_r[gi] <= 1'b1;
        else if (wr_en && hit(paddr, can_ctl0_pkg::irq_stat_off) && pwdata[gi])
          irq_stat_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_r <= can_ctl0_pkg::irq_rst;
    else if (wr_en && hit(paddr, can_ctl0_pkg::irq_mask_off))
      irq_mask_r <= pwdata[can_ctl0_pkg::ev_width-1:0];
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // R15 status bits come only from hardware
  // R6 loopback leaves these two bits undefined
  assign ctl0_val = {rx_frame_r, rx_active_r, stop_wait_r, synced_r, time_en_r, wake_en_r, sleep_req_r, init_req_r};
  assign ctl1_val = {6'h00, (mode_r == sleep_s), init_mode};

  // R1 read data registered on the clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (hit(paddr, can_ctl0_pkg::ctl0_off))
        prdata_r <= {24'h000000, ctl0_val};
      else if (hit(paddr, can_ctl0_pkg::ctl1_off))
        prdata_r <= {24'h000000, ctl1_val};
      else if (hit(paddr, can_ctl0_pkg::stamp_off))
        prdata_r <= {16'h0000, stamp_cnt_r};
      else if (hit(paddr, can_ctl0_pkg::irq_stat_off))
        prdata_r <= {29'h00000000, irq_stat_r};
      else if (hit(paddr, can_ctl0_pkg::irq_mask_off))
        prdata_r <= {29'h00000000, irq_mask_r};
      else
        prdata_r <= 32'h0000_0000;
    end
  end

  assign prdata = rd_en ? prdata_r : 32'h0000_0000;
  // R14 buffers are outside this block
endmodule : can_control0_timestamp

// File: testbench/can_control0_timestamp_properties.sv
// Port checker for the control register 0 block
`timescale 1ns/1ns
module can_ctl0_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Engine side
  input wire logic        msg_acked,
  input wire logic        abort_transfer,
  input wire logic        tx_force_recessive,
  input wire logic        bus_clk_en,
  input wire logic        stamp_we,
  // Wait mode request
  input wire logic        cpu_wait
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_err;
    psel && penable && paddr == can_ctl0_pkg::tx_pend_off |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_err_ph;
    pslverr |-> psel && penable;
  endproperty
  a_err_ph: assert property (p_err_ph) else $error("error outside access");
  property p_rd_idle;
    !(psel && penable) |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");
  property p_rd_init;
    abort_transfer[*4] ##0 (psel && penable && !pwrite && paddr == can_ctl0_pkg::ctl0_off)
      |-> prdata[7:3] == 5'h00;
  endproperty
  a_rd_init: assert property (p_rd_init) else $error("control bits not held in init");
  property p_stamp;
    stamp_we |-> $past(msg_acked);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp without acknowledge");
  property p_stamp_init;
    abort_transfer[*5] |-> !stamp_we;
  endproperty
  a_stamp_init: assert property (p_stamp_init) else $error("stamp written in init");
  property p_abort;
    $rose(abort_transfer) |-> tx_force_recessive
      && $past(psel && penable && pwrite && paddr == can_ctl0_pkg::ctl0_off);
  endproperty
  a_abort: assert property (p_abort) else $error("abort raised without a control write");
  property p_gate;
    !bus_clk_en |-> tx_force_recessive && $past(cpu_wait, 4);
  endproperty
  a_gate: assert property (p_gate) else $error("clock gated outside wait");
endmodule : can_ctl0_checker
bind can_control0_timestamp can_ctl0_checker u_can_ctl0_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .msg_acked(msg_acked),
  .abort_transfer(abort_transfer), .tx_force_recessive(tx_force_recessive),
  .bus_clk_en(bus_clk_en), .stamp_we(stamp_we), .cpu_wait(cpu_wait)
);

// File: testbench/can_node_model.sv
// Behavioural model of the protocol engine events and the receive pin
`timescale 1ns/1ns
module can_node_model (
  // Clock
  input  wire logic pclk,
  // Bus events
  output logic      bit_tick,
  output logic      frame_valid,
  output logic      rx_in_progress,
  output logic      msg_acked,
  output logic      bus_off,
  output logic      tx_buffers_empty,
  output logic      rx_pin
);
  initial
  begin
    bit_tick = 1'b0;
    frame_valid = 1'b0;
    rx_in_progress = 1'b0;
    msg_acked = 1'b0;
    bus_off = 1'b0;
    tx_buffers_empty = 1'b1;
    rx_pin = 1'b1;
  end
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge pclk) bit_tick <= 1'b1;
      @(posedge pclk) bit_tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : ticks
  task automatic dominant(input int n);
    @(posedge pclk) rx_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_pin <= 1'b1;
  endtask : dominant
  task automatic set_bus_off(input logic v);
    @(posedge pclk) bus_off <= v;
  endtask : set_bus_off
  task automatic rx_start();
    @(posedge pclk) rx_in_progress <= 1'b1;
  endtask : rx_start
  task automatic rx_end();
    @(posedge pclk);
    frame_valid <= 1'b1;
    msg_acked <= 1'b1;
    @(posedge pclk);
    frame_valid <= 1'b0;
    msg_acked <= 1'b0;
    rx_in_progress <= 1'b0;
  endtask : rx_end
endmodule : can_node_model

// File: testbench/can_control0_timestamp_tb.sv
// Self-checking bench for the control register 0 block
`timescale 1ns/1ns
module can_control0_timestamp_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_wait;
  logic        tick, fv, rxp, ack, boff, txe, rxpin;
  logic        abort, frc, clk_en, swe, irq;
  logic [15:0] sval;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count = 0;
  int          n_checks = 0;
  can_control0_timestamp u_can_control0_timestamp (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_tick(tick), .frame_valid(fv), .rx_in_progress(rxp), .msg_acked(ack), .bus_off(boff),
    .tx_buffers_empty(txe), .rx_pin(rxpin), .cpu_wait(cpu_wait), .abort_transfer(abort),
    .tx_force_recessive(frc), .bus_clk_en(clk_en), .stamp_we(swe), .stamp_value(sval), .irq(irq)
  );
  can_node_model u_can_node_model (
    .pclk(pclk), .bit_tick(tick), .frame_valid(fv), .rx_in_progress(rxp), .msg_acked(ack),
    .bus_off(boff), .tx_buffers_empty(txe), .rx_pin(rxpin)
  );
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_wait = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(can_ctl0_pkg::ctl0_off, 32'h01, "ctl0 reset");
    rd(can_ctl0_pkg::ctl1_off, 32'h01, "init ack");
    wr(can_ctl0_pkg::ctl0_off, 32'h29);
    rd(can_ctl0_pkg::ctl0_off, 32'h01, "ctl0 in init");
    wr(can_ctl0_pkg::ctl0_off, 32'h00);
    u_can_node_model.ticks(12);
    rd(can_ctl0_pkg::ctl0_off, 32'h10, "synced");
    rd(can_ctl0_pkg::ctl1_off, 32'h00, "init left");
    wr(can_ctl0_pkg::ctl0_off, 32'h50);
    rd(can_ctl0_pkg::ctl0_off, 32'h10, "status write");
    $display("test init done");
    wr(can_ctl0_pkg::ctl0_off, 32'h08);
    u_can_node_model.ticks(5);
    rd(can_ctl0_pkg::stamp_off, 32'h05, "timer count");
    wr(can_ctl0_pkg::ctl0_off, 32'h00);
    rd(can_ctl0_pkg::stamp_off, 32'h00, "timer clear");
    $display("test timer done");
    wr(can_ctl0_pkg::ctl0_off, 32'h08);
    u_can_node_model.ticks(3);
    wr(can_ctl0_pkg::irq_mask_off, 32'h00);
    u_can_node_model.rx_start();
    rd(can_ctl0_pkg::ctl0_off, 32'h58, "receiving");
    u_can_node_model.rx_end();
    @(negedge pclk);
    chk("stamp strobe", 32'h1, {31'h0, swe});
    rd(can_ctl0_pkg::ctl0_off, 32'h98, "frame flag");
    chk("stamp value", 32'h3, {16'h0, sval});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(can_ctl0_pkg::irq_stat_off, 32'h03, "events");
    wr(can_ctl0_pkg::irq_mask_off, 32'h01);
    @(negedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(can_ctl0_pkg::irq_stat_off, 32'h01);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(can_ctl0_pkg::ctl0_off, 32'h18);
    rd(can_ctl0_pkg::ctl0_off, 32'h98, "write zero");
    wr(can_ctl0_pkg::ctl0_off, 32'h88);
    rd(can_ctl0_pkg::ctl0_off, 32'h18, "write one");
    rd(can_ctl0_pkg::tx_pend_off, 32'h0, "unmapped");
    chk("pslverr", 32'h1, {31'h0, rerr});
    $display("test frame done");
    wr(can_ctl0_pkg::ctl0_off, 32'h20);
    cpu_wait <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("clk gated", 32'h0, {31'h0, clk_en});
    chk("tx recessive", 32'h1, {31'h0, frc});
    @(posedge pclk) cpu_wait <= 1'b0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("clk running", 32'h1, {31'h0, clk_en});
    $display("test wait done");
    u_can_node_model.rx_start();
    wr(can_ctl0_pkg::ctl0_off, 32'h06);
    rd(can_ctl0_pkg::ctl1_off, 32'h00, "sleep while receiving");
    u_can_node_model.rx_end();
    rd(can_ctl0_pkg::ctl1_off, 32'h02, "sleep entered");
    u_can_node_model.dominant(8);
    repeat (6) @(posedge pclk);
    rd(can_ctl0_pkg::ctl1_off, 32'h00, "woken");
    rd(can_ctl0_pkg::ctl0_off, 32'h94, "wake clears sleep");
    rd(can_ctl0_pkg::irq_stat_off, 32'h07, "wake event");
    wr(can_ctl0_pkg::ctl0_off, 32'h02);
    u_can_node_model.dominant(8);
    repeat (6) @(posedge pclk);
    rd(can_ctl0_pkg::ctl1_off, 32'h02, "wake disabled");
    wr(can_ctl0_pkg::ctl0_off, 32'h00);
    rd(can_ctl0_pkg::ctl1_off, 32'h00, "sleep left");
    $display("test sleep done");
    wr(can_ctl0_pkg::ctl0_off, 32'h08);
    u_can_node_model.ticks(2);
    wr(can_ctl0_pkg::ctl0_off, 32'h09);
    repeat (4) @(posedge pclk);
    rd(can_ctl0_pkg::ctl0_off, 32'h01, "reinit");
    rd(can_ctl0_pkg::stamp_off, 32'h00, "timer in init");
    chk("abort", 32'h1, {31'h0, abort});
    chk("recessive in init", 32'h1, {31'h0, frc});
    $display("test reinit done");
    u_can_node_model.set_bus_off(1'b1);
    wr(can_ctl0_pkg::ctl0_off, 32'h00);
    u_can_node_model.ticks(1397);
    rd(can_ctl0_pkg::ctl0_off, 32'h00, "bus-off waiting");
    u_can_node_model.ticks(11);
    rd(can_ctl0_pkg::ctl0_off, 32'h10, "bus-off synced");
    $display("test bus-off done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(can_ctl0_pkg::ctl0_off, 32'h01, "ctl0 after reset");
    rd(can_ctl0_pkg::irq_stat_off, 32'h00, "events after reset");
    $display("test reset done");
    conclude();
  end
endmodule : can_control0_timestamp_tb
